// File: core/sacu_clk_div.sv
// Conversion clock prescaler, divide by four or two
`timescale 1ns/1ns
`default_nettype none
module sacu_clk_div (
  input wire logic clk_i,
  input wire logic reset_n_i,
  sacu_conv_if.div conv
);
  import sacu_pkg::*;

  typedef struct packed {
    logic [1:0] cnt;
  } sacu_div_state_type;

  sacu_div_state_type q;
  sacu_div_state_type d;
  logic [1:0] last;

  // Rate select picks the terminal count
  assign last = conv.div_by_two ? SACU_DIV2_LAST : SACU_DIV4_LAST;
  assign conv.tick = conv.run && (q.cnt == last);

  // Count restarts with every abort or stop
  always_comb begin
    d = q;
    if (!conv.run || conv.abort) begin
      d.cnt = 2'h0;
    end else if (q.cnt >= last) begin
      d.cnt = 2'h0;
    end else begin
      d.cnt = q.cnt + 2'h1;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end
endmodule
`default_nettype wire

// File: core/sacu_sar_engine.sv
// Successive-approximation sequencer: one sample tick then ten decisions
`timescale 1ns/1ns
`default_nettype none
module sacu_sar_engine (
  input wire logic clk_i,
  input wire logic reset_n_i,
  sacu_conv_if.eng conv
);
  import sacu_pkg::*;

  typedef struct packed {
    sacu_eng_state_type st;
    logic [3:0] bit_idx;
    logic [9:0] trial;
    logic [9:0] result;
    logic done;
  } sacu_eng_q_type;

  sacu_eng_q_type q;
  sacu_eng_q_type d;

  assign conv.busy = (q.st != SACU_ST_IDLE);
  assign conv.sample = (q.st == SACU_ST_SAMPLE);
  assign conv.trial = q.trial;
  assign conv.result = q.result;
  assign conv.done = q.done;

  // Sequencer; loops back to sampling after each result
  always_comb begin
    logic [9:0] decided;
    decided = q.trial;
    d = q;
    d.done = 1'b0;
    if (!conv.cmp_above) begin
      decided[q.bit_idx] = 1'b0;
    end
    if (!conv.run || conv.abort) begin
      d.st = SACU_ST_IDLE;
      d.trial = '0;
    end else begin
      case (q.st)
        SACU_ST_IDLE: begin
          d.st = SACU_ST_SAMPLE;
        end
        SACU_ST_SAMPLE: begin
          if (conv.tick) begin
            d.st = SACU_ST_DECIDE;
            d.trial = SACU_SAR_FIRST_TRIAL;
            d.bit_idx = SACU_SAR_MSB_IDX;
          end
        end
        SACU_ST_DECIDE: begin
          if (conv.tick) begin
            d.trial = decided;
            if (q.bit_idx == 4'h0) begin
              d.result = decided;
              d.done = 1'b1;
              d.st = SACU_ST_SAMPLE;
            end else begin
              d.bit_idx = q.bit_idx - 4'h1;
              d.trial[q.bit_idx - 4'h1] = 1'b1;
            end
          end
        end
        default: begin
          d.st = SACU_ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      q <= '{st: SACU_ST_IDLE, bit_idx: 4'h0, trial: 10'h000,
             result: SACU_RESULT_RST, done: 1'b0};
    end else begin
      q <= d;
    end
  end
endmodule
`default_nettype wire

// File: core/sacu_top.sv
// Converter control unit: register file, bus slave, halt handling and interrupt
//
// Overview of operation
// - Writing a different channel aborts the conversion, clears done, restarts on new input.
// - Processor wait mode has no influence on converter operation or state.
// - Halt disables the converter; after wake, conversions wait a settle interval.
// - Done flag in bit 7 is read-only; hardware sets it on each result.
// - Reading high result or writing the control register clears the done flag.
// - Converter-on bit 5 enables and starts conversion; clearing it stops everything.
// - While enabled, conversions of the selected channel repeat back to back.
// - Bits 3:0 select the analog input as a binary index 0 to 15.
// - High result register reads result bits 9 down to 2, read-only.
// - Low result register reads zeros above, result bits 1:0 below, read-only.
// - Inputs above the reference give all ones, below give zero, no overflow.
`timescale 1ns/1ns
`default_nettype none
module sacu_top #(
  parameter logic [15:0] SETTLE_CYCLES = sacu_pkg::SACU_SETTLE_CYCLES
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  // AXI4-Lite write address
  input wire logic s_axil_awvalid_i,
  output logic s_axil_awready_o,
  input wire logic [sacu_pkg::SACU_ADDR_W-1:0] s_axil_awaddr_i,
  input wire logic [2:0] s_axil_awprot_i,
  // AXI4-Lite write data
  input wire logic s_axil_wvalid_i,
  output logic s_axil_wready_o,
  input wire logic [31:0] s_axil_wdata_i,
  input wire logic [3:0] s_axil_wstrb_i,
  // AXI4-Lite write response
  output logic s_axil_bvalid_o,
  input wire logic s_axil_bready_i,
  output logic [1:0] s_axil_bresp_o,
  // AXI4-Lite read address
  input wire logic s_axil_arvalid_i,
  output logic s_axil_arready_o,
  input wire logic [sacu_pkg::SACU_ADDR_W-1:0] s_axil_araddr_i,
  input wire logic [2:0] s_axil_arprot_i,
  // AXI4-Lite read data
  output logic s_axil_rvalid_o,
  input wire logic s_axil_rready_i,
  output logic [31:0] s_axil_rdata_o,
  output logic [1:0] s_axil_rresp_o,
  // Low-power state of the processor
  input wire logic halt_mode_i,
  // Analog front end
  output logic [3:0] channel_select_o,
  output logic converter_power_o,
  output logic sample_o,
  output logic [9:0] dac_code_o,
  input wire logic cmp_above_i,
  // Interrupt
  output logic irq_o
);
  import sacu_pkg::*;

  typedef struct packed {
    logic aw_held;
    logic [SACU_ADDR_W-1:0] aw_addr;
    logic w_held;
    logic [7:0] w_data;
    logic w_lane;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic eoc;
    logic speed;
    logic conv_on;
    logic [3:0] chan;
    logic [9:0] result;
    logic [1:0] irq_stat;
    logic [1:0] irq_mask;
    logic halt_prev;
    logic [15:0] settle_cnt;
    logic settled;
    logic power;
  } sacu_top_state_type;

  localparam sacu_top_state_type STATE_RST = '{
    aw_held: 1'b0,
    aw_addr: '0,
    w_held: 1'b0,
    w_data: 8'h00,
    w_lane: 1'b0,
    bvalid: 1'b0,
    bresp: SACU_RESP_OKAY,
    rvalid: 1'b0,
    rdata: 32'h0000_0000,
    rresp: SACU_RESP_OKAY,
    eoc: SACU_CSR_RST[SACU_EOC_BIT],
    speed: SACU_CSR_RST[SACU_SPEED_BIT],
    conv_on: SACU_CSR_RST[SACU_ON_BIT],
    chan: SACU_CSR_RST[SACU_CH_MSB:0],
    result: SACU_RESULT_RST,
    irq_stat: SACU_IRQ_RST,
    irq_mask: SACU_IRQ_RST,
    halt_prev: 1'b0,
    settle_cnt: 16'h0000,
    settled: 1'b1,
    power: 1'b0
  };

  sacu_top_state_type q;
  sacu_top_state_type d;

  sacu_conv_if conv ();

  logic aw_take;
  logic w_take;
  logic wr_go;
  logic ar_take;
  logic [9:0] wr_idx;
  logic [9:0] rd_idx;
  logic abort_c;
  logic csr_write;
  logic high_read;
  logic [7:0] csr_view;

  // Prescaler for the conversion clock
  sacu_clk_div u_div (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .conv(conv)
  );

  // Successive-approximation sequencer
  sacu_sar_engine u_engine (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .conv(conv)
  );

  // Bus handshakes; one write and one read in flight at most
  assign s_axil_awready_o = !q.aw_held && !q.bvalid;
  assign s_axil_wready_o = !q.w_held && !q.bvalid;
  assign s_axil_arready_o = !q.rvalid;
  assign aw_take = s_axil_awvalid_i && s_axil_awready_o;
  assign w_take = s_axil_wvalid_i && s_axil_wready_o;
  assign ar_take = s_axil_arvalid_i && s_axil_arready_o;
  assign wr_go = q.aw_held && q.w_held && !q.bvalid;
  assign wr_idx = q.aw_addr[SACU_ADDR_W-1:2];
  assign rd_idx = s_axil_araddr_i[SACU_ADDR_W-1:2];

  // Register-bus outputs
  assign s_axil_bvalid_o = q.bvalid;
  assign s_axil_bresp_o = q.bresp;
  assign s_axil_rvalid_o = q.rvalid;
  assign s_axil_rdata_o = q.rdata;
  assign s_axil_rresp_o = q.rresp;

  // Control write effects, taken only with byte lane 0 enabled
  assign csr_write = wr_go && q.w_lane && (wr_idx == SACU_IDX_CTRL_STATUS);
  assign abort_c = csr_write && (q.w_data[SACU_CH_MSB:0] != q.chan);
  assign high_read = ar_take && (rd_idx == SACU_IDX_RESULT_HIGH);

  // Readback of the control register; reserved bit reads zero
  assign csr_view = {q.eoc, q.speed, q.conv_on, 1'b0, q.chan};

  // Links to the prescaler and the sequencer
  assign conv.div_by_two = q.speed;
  assign conv.run = q.conv_on && !halt_mode_i && q.settled;
  assign conv.abort = abort_c;
  assign conv.cmp_above = cmp_above_i;

  // Analog front-end drive
  assign channel_select_o = q.chan;
  assign converter_power_o = q.power;
  assign sample_o = conv.sample;
  assign dac_code_o = conv.trial;

  // Level interrupt from unmasked sticky events
  assign irq_o = |(q.irq_stat & q.irq_mask);

  // Next-state logic for the whole unit
  always_comb begin
    d = q;
    d.halt_prev = halt_mode_i;
    d.power = q.conv_on && !halt_mode_i;

    // Write address and data accepted in either order
    if (aw_take) begin
      d.aw_held = 1'b1;
      d.aw_addr = s_axil_awaddr_i;
    end
    if (w_take) begin
      d.w_held = 1'b1;
      d.w_data = s_axil_wdata_i[7:0];
      d.w_lane = s_axil_wstrb_i[0];
    end

    // Write performed once both halves are held
    if (wr_go) begin
      d.aw_held = 1'b0;
      d.w_held = 1'b0;
      d.bvalid = 1'b1;
      d.bresp = SACU_RESP_OKAY;
      case (wr_idx)
        SACU_IDX_CTRL_STATUS: begin
          if (q.w_lane) begin
            d.eoc = 1'b0;
            d.speed = q.w_data[SACU_SPEED_BIT];
            d.conv_on = q.w_data[SACU_ON_BIT];
            d.chan = q.w_data[SACU_CH_MSB:0];
          end
        end
        SACU_IDX_IRQ_STATUS: begin
          if (q.w_lane) begin
            d.irq_stat = q.irq_stat & ~q.w_data[1:0];
          end
        end
        SACU_IDX_IRQ_MASK: begin
          if (q.w_lane) begin
            d.irq_mask = q.w_data[1:0];
          end
        end
        SACU_IDX_RESULT_HIGH, SACU_IDX_RESULT_LOW, SACU_IDX_UNIT_STATUS: begin
          d.bresp = SACU_RESP_OKAY;
        end
        default: begin
          d.bresp = SACU_RESP_SLVERR;
        end
      endcase
    end
    if (q.bvalid && s_axil_bready_i) begin
      d.bvalid = 1'b0;
    end

    // Read data captured when the address is taken
    if (q.rvalid && s_axil_rready_i) begin
      d.rvalid = 1'b0;
    end
    if (ar_take) begin
      d.rvalid = 1'b1;
      d.rresp = SACU_RESP_OKAY;
      d.rdata = 32'h0000_0000;
      case (rd_idx)
        SACU_IDX_CTRL_STATUS: begin
          d.rdata[7:0] = csr_view;
        end
        SACU_IDX_RESULT_HIGH: begin
          d.rdata[7:0] = q.result[9:2];
        end
        SACU_IDX_RESULT_LOW: begin
          d.rdata[7:0] = {6'h00, q.result[1:0]};
        end
        SACU_IDX_IRQ_STATUS: begin
          d.rdata[1:0] = q.irq_stat;
        end
        SACU_IDX_IRQ_MASK: begin
          d.rdata[1:0] = q.irq_mask;
        end
        SACU_IDX_UNIT_STATUS: begin
          d.rdata[2:0] = {halt_mode_i, conv.busy, q.settled};
        end
        default: begin
          d.rresp = SACU_RESP_SLVERR;
        end
      endcase
    end

    // High result read clears done; a new result below still wins
    if (high_read) begin
      d.eoc = 1'b0;
    end

    // Stabilisation count after wake-up from halt
    if (halt_mode_i) begin
      d.settled = 1'b0;
      d.settle_cnt = SETTLE_CYCLES;
    end else if (q.halt_prev) begin
      d.settled = 1'b0;
      d.settle_cnt = SETTLE_CYCLES;
    end else if (!q.settled) begin
      if (q.settle_cnt <= 16'h0001) begin
        d.settled = 1'b1;
        d.settle_cnt = 16'h0000;
        d.irq_stat[SACU_IRQ_SETTLE_BIT] = 1'b1;
      end else begin
        d.settle_cnt = q.settle_cnt - 16'h0001;
      end
    end

    // Result capture last so a new result wins over a clear
    if (conv.done) begin
      d.result = conv.result;
      d.eoc = 1'b1;
      d.irq_stat[SACU_IRQ_DONE_BIT] = 1'b1;
    end
  end

  // All state of the unit in one register
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      q <= STATE_RST;
    end else begin
      q <= d;
    end
  end
endmodule
`default_nettype wire

// File: shared/sacu_conv_if.sv
// Internal link between control registers, prescaler and conversion engine
`timescale 1ns/1ns
`default_nettype none
interface sacu_conv_if;
  logic div_by_two;
  logic run;
  logic abort;
  logic tick;
  logic cmp_above;
  logic busy;
  logic done;
  logic sample;
  logic [9:0] trial;
  logic [9:0] result;
  modport top(output div_by_two, run, abort, cmp_above,
              input tick, busy, done, sample, trial, result);
  modport div(input div_by_two, run, abort, output tick);
  modport eng(input run, abort, tick, cmp_above,
              output busy, done, sample, trial, result);
endinterface
`default_nettype wire

// File: shared/sacu_pkg.sv
// Shared constants and types for the successive-approximation converter control unit
package sacu_pkg;

  // Bus geometry and answers
  localparam int unsigned SACU_ADDR_W = 12;
  localparam logic [1:0] SACU_RESP_OKAY = 2'b00;
  localparam logic [1:0] SACU_RESP_SLVERR = 2'b10;

  // Register indexes; byte address is four times the index
  localparam logic [9:0] SACU_IDX_CTRL_STATUS = 10'h070;
  localparam logic [9:0] SACU_IDX_RESULT_HIGH = 10'h071;
  localparam logic [9:0] SACU_IDX_RESULT_LOW = 10'h072;
  localparam logic [9:0] SACU_IDX_IRQ_STATUS = 10'h074;
  localparam logic [9:0] SACU_IDX_IRQ_MASK = 10'h075;
  localparam logic [9:0] SACU_IDX_UNIT_STATUS = 10'h076;

  // Control/status field positions
  localparam int unsigned SACU_EOC_BIT = 7;
  localparam int unsigned SACU_SPEED_BIT = 6;
  localparam int unsigned SACU_ON_BIT = 5;
  localparam int unsigned SACU_CH_MSB = 3;

  // Interrupt status bit positions
  localparam int unsigned SACU_IRQ_DONE_BIT = 0;
  localparam int unsigned SACU_IRQ_SETTLE_BIT = 1;

  // Values after reset
  localparam logic [7:0] SACU_CSR_RST = 8'h00;
  localparam logic [9:0] SACU_RESULT_RST = 10'h000;
  localparam logic [1:0] SACU_IRQ_RST = 2'h0;

  // Conversion clock dividers: last count of the prescaler
  localparam logic [1:0] SACU_DIV4_LAST = 2'h3;
  localparam logic [1:0] SACU_DIV2_LAST = 2'h1;

  // Successive approximation
  localparam int unsigned SACU_RES_W = 10;
  localparam logic [3:0] SACU_SAR_MSB_IDX = 4'h9;
  localparam logic [9:0] SACU_SAR_FIRST_TRIAL = 10'h200;

  // Stabilisation after halt wake-up
  localparam int unsigned SACU_CLK_PERIOD_NS = 50;
  localparam int unsigned SACU_SETTLE_NS = 30000;
  localparam logic [15:0] SACU_SETTLE_CYCLES =
    16'((SACU_SETTLE_NS + SACU_CLK_PERIOD_NS - 1) / SACU_CLK_PERIOD_NS);

  // Conversion engine states
  typedef enum logic [2:0] {
    SACU_ST_IDLE = 3'b001,
    SACU_ST_SAMPLE = 3'b010,
    SACU_ST_DECIDE = 3'b100
  } sacu_eng_state_type;

endpackage

// File: testbench/sacu_analog_model.sv
// Analog front end model: sixteen input levels, sample and hold, comparator
`timescale 1ns/1ns
`default_nettype none
module sacu_analog_model (
  input wire logic clk_i,
  input wire logic power_i,
  input wire logic sample_i,
  input wire logic [3:0] channel_select_i,
  input wire logic [9:0] dac_code_i,
  input wire logic [15:0][10:0] level_i,
  output logic cmp_above_o
);
  logic [10:0] held_q;
  logic junk_q = 1'b0;
  // Follows the selected input while sampling, holds it for the decisions
  always_ff @(posedge clk_i) begin
    junk_q <= !junk_q;
    if (sample_i) begin
      held_q <= level_i[channel_select_i];
    end
  end
  // Levels above full scale compare high on every code; unpowered output is noise
  assign cmp_above_o = power_i ? (held_q >= {1'b0, dac_code_i}) : junk_q;
endmodule
`default_nettype wire

// File: testbench/sacu_top_props.sv
// Port checker for the converter control unit
`timescale 1ns/1ns
`default_nettype none
module sacu_top_props #(
  parameter logic [15:0] SETTLE_CYCLES = 16'h0008
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic s_axil_awready_o,
  input wire logic s_axil_wready_o,
  input wire logic s_axil_bvalid_o,
  input wire logic s_axil_bready_i,
  input wire logic [1:0] s_axil_bresp_o,
  input wire logic s_axil_arvalid_i,
  input wire logic s_axil_arready_o,
  input wire logic [sacu_pkg::SACU_ADDR_W-1:0] s_axil_araddr_i,
  input wire logic s_axil_rvalid_o,
  input wire logic s_axil_rready_i,
  input wire logic [31:0] s_axil_rdata_o,
  input wire logic halt_mode_i,
  input wire logic converter_power_o,
  input wire logic sample_o
);
  import sacu_pkg::*;
  logic low_q;
  // Notes whether the read in flight targets the low result
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      low_q <= 1'b0;
    end else if (s_axil_arvalid_i && s_axil_arready_o) begin
      low_q <= s_axil_araddr_i == {SACU_IDX_RESULT_LOW, 2'b00};
    end
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  bresp_hold_a: assert property (s_axil_bvalid_o && !s_axil_bready_i |=>
    s_axil_bvalid_o && $stable(s_axil_bresp_o)) else $error("write answer not held");
  rdata_hold_a: assert property (s_axil_rvalid_o && !s_axil_rready_i |=>
    s_axil_rvalid_o && $stable(s_axil_rdata_o)) else $error("read answer not held");
  read_answer_a: assert property (s_axil_arvalid_i && s_axil_arready_o |=>
    s_axil_rvalid_o) else $error("read answer late");
  write_block_a: assert property (s_axil_bvalid_o |->
    !s_axil_awready_o && !s_axil_wready_o) else $error("write taken while answering");
  read_block_a: assert property (s_axil_rvalid_o |-> !s_axil_arready_o)
    else $error("read taken while answering");
  low_zero_a: assert property (s_axil_rvalid_o && low_q |->
    s_axil_rdata_o[31:2] == 30'h0) else $error("low result upper bits set");
  halt_off_a: assert property (halt_mode_i |=>
    !converter_power_o && !sample_o) else $error("converter active in halt");
  settle_wait_a: assert property ($fell(halt_mode_i) |->
    !sample_o [*6]) else $error("sampling before settle interval");
endmodule
bind sacu_top sacu_top_props #(.SETTLE_CYCLES(SETTLE_CYCLES)) sacu_top_props_inst (
  .clk_i(clk_i), .reset_n_i(reset_n_i),
  .s_axil_awready_o(s_axil_awready_o), .s_axil_wready_o(s_axil_wready_o),
  .s_axil_bvalid_o(s_axil_bvalid_o), .s_axil_bready_i(s_axil_bready_i),
  .s_axil_bresp_o(s_axil_bresp_o), .s_axil_arvalid_i(s_axil_arvalid_i),
  .s_axil_arready_o(s_axil_arready_o), .s_axil_araddr_i(s_axil_araddr_i),
  .s_axil_rvalid_o(s_axil_rvalid_o), .s_axil_rready_i(s_axil_rready_i),
  .s_axil_rdata_o(s_axil_rdata_o), .halt_mode_i(halt_mode_i),
  .converter_power_o(converter_power_o), .sample_o(sample_o)
);
`default_nettype wire

// File: testbench/sar_adc_control_unit_bench.sv
// Bench: register traffic, conversions on every channel, interrupt and halt
`timescale 1ns/1ns
`default_nettype none
module sar_adc_control_unit_bench;
  import sacu_pkg::*;
  logic clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic halt = 1'b0;
  logic awv = 1'b0;
  logic wv = 1'b0;
  logic bre = 1'b0;
  logic arv = 1'b0;
  logic rre = 1'b0;
  logic [11:0] awa = 12'h000;
  logic [11:0] ara = 12'h000;
  logic [31:0] wd = 32'h0;
  logic awr, wrdy, bv, arr, rv, pwr, smp, irq, cmp;
  logic [31:0] rd, val;
  logic [1:0] br, rr, resp;
  logic [3:0] chs;
  logic [9:0] dac;
  logic [15:0][10:0] lvl;
  logic [31:0] rnd = 32'h9;
  int lv[16];
  int bad_count = 0;
  int n_tests = 0;
  int cyc = 0;
  int exp_res;

  sacu_top #(.SETTLE_CYCLES(16'h0008)) sacu_top_inst (
    .clk_i(clk_i), .reset_n_i(reset_n_i),
    .s_axil_awvalid_i(awv), .s_axil_awready_o(awr), .s_axil_awaddr_i(awa),
    .s_axil_awprot_i(3'h0), .s_axil_wvalid_i(wv), .s_axil_wready_o(wrdy),
    .s_axil_wdata_i(wd), .s_axil_wstrb_i(4'h1), .s_axil_bvalid_o(bv),
    .s_axil_bready_i(bre), .s_axil_bresp_o(br), .s_axil_arvalid_i(arv),
    .s_axil_arready_o(arr), .s_axil_araddr_i(ara), .s_axil_arprot_i(3'h0),
    .s_axil_rvalid_o(rv), .s_axil_rready_i(rre), .s_axil_rdata_o(rd),
    .s_axil_rresp_o(rr), .halt_mode_i(halt), .channel_select_o(chs),
    .converter_power_o(pwr), .sample_o(smp), .dac_code_o(dac),
    .cmp_above_i(cmp), .irq_o(irq)
  );

  sacu_analog_model sacu_analog_model_inst (
    .clk_i(clk_i), .power_i(pwr), .sample_i(smp), .channel_select_i(chs),
    .dac_code_i(dac), .level_i(lvl), .cmp_above_o(cmp)
  );

  // Clock of 50 ns period
  initial begin
    forever #25 clk_i = ~clk_i;
  end

  // Hang guard
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 30000) begin
      bad_count++;
      test_done();
    end
  end

  function automatic logic [31:0] xs(input logic [31:0] x);
    logic [31:0] y;
    y = x ^ (x << 13);
    y = y ^ (y >> 17);
    return y ^ (y << 5);
  endfunction

  function automatic logic [11:0] ad(input logic [9:0] i);
    return {i, 2'b00};
  endfunction

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Bus write: both halves offered together, answer awaited with bready high
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic ah, wh, bh;
    @(posedge clk_i);
    awv <= 1'b1;
    awa <= a;
    wv <= 1'b1;
    wd <= {24'h0, d};
    bre <= 1'b1;
    bh = 1'b0;
    while (!bh) begin
      @(negedge clk_i);
      ah = awv && awr;
      wh = wv && wrdy;
      bh = bv;
      resp = br;
      @(posedge clk_i);
      if (ah) awv <= 1'b0;
      if (wh) wv <= 1'b0;
    end
    bre <= 1'b0;
  endtask

  // Bus read; data and response land in val and resp
  task automatic rd_reg(input logic [11:0] a);
    logic ah, rh;
    @(posedge clk_i);
    arv <= 1'b1;
    ara <= a;
    rre <= 1'b1;
    rh = 1'b0;
    while (!rh) begin
      @(negedge clk_i);
      ah = arv && arr;
      rh = rv;
      val = rd;
      resp = rr;
      @(posedge clk_i);
      if (ah) arv <= 1'b0;
    end
    rre <= 1'b0;
  endtask

  task automatic wait_done();
    val = 32'h0;
    while (val[SACU_EOC_BIT] !== 1'b1) rd_reg(ad(SACU_IDX_CTRL_STATUS));
  endtask

  task automatic test_done();
    $display("Checks %0d, mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    for (int i = 0; i < 16; i++) begin
      rnd = xs(rnd);
      lv[i] = (i == 0) ? 0 : (i == 15) ? 1100 : int'(rnd % 1100);
      lvl[i] = 11'(lv[i]);
    end
    repeat (16) @(posedge clk_i);
    reset_n_i <= 1'b1;
    for (int r = 0; r < 3; r++) begin
      rd_reg(ad(SACU_IDX_CTRL_STATUS + 10'(r)));
      chk("reset value", val, 32'h0);
    end
    rd_reg(12'h000);
    chk("unmapped read", 32'(resp), 32'(SACU_RESP_SLVERR));
    wr(12'h004, 8'hff);
    chk("unmapped write", 32'(resp), 32'(SACU_RESP_SLVERR));
    // Each write after the first changes channel and rate while converting
    for (int i = 0; i < 16; i++) begin
      wr(ad(SACU_IDX_CTRL_STATUS), {1'b0, i[0], 2'b10, i[3:0]});
      rd_reg(ad(SACU_IDX_CTRL_STATUS));
      chk("ctrl after write", val, 32'({i[0], 2'b10, i[3:0]}));
      chk("channel out", 32'(chs), i);
      wait_done();
      exp_res = lv[i] > 1023 ? 1023 : lv[i];
      rd_reg(ad(SACU_IDX_RESULT_LOW));
      chk("result low", val, 32'(exp_res % 4));
      rd_reg(ad(SACU_IDX_RESULT_HIGH));
      chk("result high", val, 32'(exp_res / 4));
      rd_reg(ad(SACU_IDX_CTRL_STATUS));
      chk("done after high read", 32'(val[SACU_EOC_BIT]), 32'h0);
    end
    wait_done();
    rd_reg(ad(SACU_IDX_RESULT_HIGH));
    chk("repeat result", val, 32'hff);
    // Interrupt masked, unmasked, then cleared with the converter off
    chk("irq masked", 32'(irq), 32'h0);
    wr(ad(SACU_IDX_IRQ_MASK), 8'h01);
    @(negedge clk_i);
    chk("irq unmasked", 32'(irq), 32'h1);
    wr(ad(SACU_IDX_CTRL_STATUS), 8'h0f);
    wr(ad(SACU_IDX_IRQ_STATUS), 8'h03);
    @(negedge clk_i);
    chk("irq cleared", 32'(irq), 32'h0);
    repeat (60) @(posedge clk_i);
    chk("irq while off", 32'(irq), 32'h0);
    rd_reg(ad(SACU_IDX_CTRL_STATUS));
    chk("ctrl off", val, 32'h0f);
    // Halt in mid-run, then settle and convert again
    wr(ad(SACU_IDX_CTRL_STATUS), 8'h23);
    halt <= 1'b1;
    repeat (20) @(posedge clk_i);
    chk("power in halt", 32'(pwr), 32'h0);
    rd_reg(ad(SACU_IDX_UNIT_STATUS));
    chk("unit status halt", val, 32'h4);
    halt <= 1'b0;
    wait_done();
    exp_res = lv[3] > 1023 ? 1023 : lv[3];
    rd_reg(ad(SACU_IDX_RESULT_HIGH));
    chk("result after halt", val, 32'(exp_res / 4));
    rd_reg(ad(SACU_IDX_IRQ_STATUS));
    chk("settle event", 32'(val[SACU_IRQ_SETTLE_BIT]), 32'h1);
    test_done();
  end
endmodule
`default_nettype wire
